// *** hdl/ubg_pkg.sv ***
// ubg_pkg: shared constants and state types for the serial data buffer and baud generator.
// assumes an 8-bit register address space and a single system clock.
package ubg_pkg;

    // register offsets
    localparam logic [7:0] UBG_ADDR_BAUD_CTRL = 8'h87;
    localparam logic [7:0] UBG_ADDR_SERIAL_CTRL = 8'h98;
    localparam logic [7:0] UBG_ADDR_DATA_BUF = 8'h99;
    localparam logic [7:0] UBG_ADDR_T2_CTRL = 8'hA0;
    localparam logic [7:0] UBG_ADDR_T1_RELOAD_LO = 8'hA1;
    localparam logic [7:0] UBG_ADDR_T1_RELOAD_HI = 8'hA2;
    localparam logic [7:0] UBG_ADDR_T1_CTRL = 8'hA3;
    localparam logic [7:0] UBG_ADDR_T2_RELOAD_LO = 8'hA4;
    localparam logic [7:0] UBG_ADDR_T2_RELOAD_HI = 8'hA5;
    localparam logic [7:0] UBG_ADDR_IRQ_STATUS = 8'hA8;
    localparam logic [7:0] UBG_ADDR_IRQ_CLEAR = 8'hA9;
    localparam logic [7:0] UBG_ADDR_IRQ_ENABLE = 8'hAA;

    // field positions
    localparam int UBG_BAUD_DIV16_BIT = 7;
    localparam int UBG_MODE_HI_BIT = 7;
    localparam int UBG_MODE_LO_BIT = 6;
    localparam int UBG_AUX_BIT = 5;
    localparam int UBG_RX_EN_BIT = 4;
    localparam int UBG_TX9_BIT = 3;
    localparam int UBG_RX9_BIT = 2;
    localparam int UBG_TX_DONE_BIT = 1;
    localparam int UBG_RX_DONE_BIT = 0;
    localparam int UBG_TX_SEL_BIT = 4;
    localparam int UBG_RX_SEL_BIT = 5;
    localparam int UBG_T1_RUN_BIT = 0;

    // reset values
    localparam logic [7:0] UBG_BYTE_RESET = 8'h00;
    localparam logic [15:0] UBG_RELOAD_RESET = 16'h0000;

    // frame mode encodings
    localparam logic [1:0] UBG_MODE_SYNC = 2'b00;
    localparam logic [1:0] UBG_MODE_ASYNC10 = 2'b01;
    localparam logic [1:0] UBG_MODE_RSVD = 2'b10;
    localparam logic [1:0] UBG_MODE_ASYNC11 = 2'b11;

    // bit timing counts in system clocks
    localparam int UBG_PER_W = 20;
    localparam logic [UBG_PER_W-1:0] UBG_SYNC_DIV_SLOW = 20'h0_000C;
    localparam logic [UBG_PER_W-1:0] UBG_SYNC_DIV_FAST = 20'h0_0004;
    localparam logic [UBG_PER_W-1:0] UBG_MIN_PERIOD = 20'h0_0002;

    // frame lengths in bits, and receive bit counts after the start bit
    localparam logic [3:0] UBG_SYNC_BITS = 4'h8;
    localparam logic [3:0] UBG_ASYNC10_BITS = 4'hA;
    localparam logic [3:0] UBG_ASYNC11_BITS = 4'hB;
    localparam logic [3:0] UBG_RX8_BITS = 4'h8;
    localparam logic [3:0] UBG_RX9_BITS = 4'h9;

    typedef enum logic [2:0] {
        UBG_TX_IDLE = 3'b001,
        UBG_TX_ASYNC = 3'b010,
        UBG_TX_SYNC = 3'b100
    } ubg_tx_state_t;

    typedef enum logic [2:0] {
        UBG_RX_IDLE = 3'b001,
        UBG_RX_START = 3'b010,
        UBG_RX_DATA = 3'b100
    } ubg_rx_state_t;

endpackage

// *** hdl/ubg_uart.sv ***
// ubg_uart: serial data buffer, frame engines and baud generation of the primary serial port.
// assumes a synchronous register port on clk_sys and an external serial peer on txd/rxd.
// How it works
// RQ1 - buffer write loads shifter, starts frame
// RQ2 - buffer read returns separate receive latch
// RQ3 - sync mode, aux clear: clock/12
// RQ4 - sync mode, aux set: clock/4
// RQ5 - divide-by-16 only in async modes
// RQ6 - both select bits zero: first timer
// RQ7 - first timer: clock/reload, optional /16
// RQ8 - software keeps first reload above 0x0010
// RQ9 - software keeps first timer run cleared
// RQ10 - any select bit set: second timer
// RQ11 - second timer: clock/reload, optional /16
// RQ12 - software keeps second reload above 0x0010
// RQ13 - mode 00: 8-bit sync, LSB first
// RQ14 - 01 ten-bit, 11 eleven-bit, 10 reserved
// RQ15 - ninth bit sent from control, stored received
// RQ16 - aux set in 11: flag needs ninth=1
// RQ17 - done flags sticky until software clears
// RQ18 - receive only while receive enable set
`timescale 1ns/1ps
`default_nettype none
module ubg_uart
    import ubg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic txd_out,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic irq
);

    // bit period in system clocks for the current mode
    function automatic logic [UBG_PER_W-1:0] bit_period(
        input logic [1:0] mode,
        input logic aux,
        input logic div16,
        input logic [15:0] reload
    );
        logic [UBG_PER_W-1:0] p;
        if (mode == UBG_MODE_SYNC) begin
            p = aux ? UBG_SYNC_DIV_FAST : UBG_SYNC_DIV_SLOW; // [RQ3] [RQ4]
        end else if (div16) begin
            p = {reload, 4'h0}; // [RQ5] [RQ7] [RQ11]
        end else begin
            p = {4'h0, reload};
        end
        if (p < UBG_MIN_PERIOD) begin
            p = UBG_MIN_PERIOD;
        end
        return p;
    endfunction

    logic div16_q;
    logic [1:0] mode_q;
    logic aux_q, rx_en_q, tx9_q, rx9_q;
    logic tx_sel_q, rx_sel_q, t1_run_q;
    logic [15:0] t1_reload_q, t2_reload_q;
    logic [1:0] irq_status_q, irq_en_q;
    logic [7:0] rx_latch_q, rdata_q;
    logic rxd_meta_q, rxd_s_q, rxd_prev_q;
    ubg_tx_state_t tx_state_q;
    ubg_rx_state_t rx_state_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_bits_q;
    logic [UBG_PER_W-1:0] tx_cnt_q;
    logic sync_rx_q, shift_clk_q;
    logic [8:0] rx_sh_q;
    logic [3:0] rx_bits_q;
    logic [UBG_PER_W-1:0] rx_cnt_q;
    logic tx_done_evt, rx_done_evt, rx_accept;
    logic [7:0] rx_data;
    logic rx_ninth;
    logic [15:0] reload_sel;
    logic [UBG_PER_W-1:0] per, half;
    logic wr_buf, is_async;

    // baud source choice and derived timing
    assign reload_sel = (tx_sel_q | rx_sel_q) ? t2_reload_q : t1_reload_q; // [RQ6] [RQ10]
    assign per = bit_period(mode_q, aux_q, div16_q, reload_sel);
    assign half = {1'b0, per[UBG_PER_W-1:1]};
    assign wr_buf = reg_wr && (reg_addr == UBG_ADDR_DATA_BUF);
    assign is_async = (mode_q == UBG_MODE_ASYNC10) || (mode_q == UBG_MODE_ASYNC11);

    // receive pin synchroniser, edge history from the second stage only
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rxd_meta_q <= 1'b1;
            rxd_s_q <= 1'b1;
            rxd_prev_q <= 1'b1;
        end else begin
            rxd_meta_q <= rxd_in;
            rxd_s_q <= rxd_meta_q;
            rxd_prev_q <= rxd_s_q;
        end
    end

    // software control registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div16_q <= 1'b0;
            mode_q <= UBG_MODE_SYNC;
            aux_q <= 1'b0;
            rx_en_q <= 1'b0;
            tx9_q <= 1'b0;
            tx_sel_q <= 1'b0;
            rx_sel_q <= 1'b0;
            t1_run_q <= 1'b0;
            t1_reload_q <= UBG_RELOAD_RESET;
            t2_reload_q <= UBG_RELOAD_RESET;
            irq_en_q <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                UBG_ADDR_BAUD_CTRL: div16_q <= reg_wdata[UBG_BAUD_DIV16_BIT];
                UBG_ADDR_SERIAL_CTRL: begin
                    mode_q <= {reg_wdata[UBG_MODE_HI_BIT], reg_wdata[UBG_MODE_LO_BIT]};
                    aux_q <= reg_wdata[UBG_AUX_BIT];
                    rx_en_q <= reg_wdata[UBG_RX_EN_BIT];
                    tx9_q <= reg_wdata[UBG_TX9_BIT];
                end
                UBG_ADDR_T2_CTRL: begin
                    tx_sel_q <= reg_wdata[UBG_TX_SEL_BIT];
                    rx_sel_q <= reg_wdata[UBG_RX_SEL_BIT];
                end
                UBG_ADDR_T1_RELOAD_LO: t1_reload_q[7:0] <= reg_wdata;
                UBG_ADDR_T1_RELOAD_HI: t1_reload_q[15:8] <= reg_wdata;
                UBG_ADDR_T1_CTRL: t1_run_q <= reg_wdata[UBG_T1_RUN_BIT];
                UBG_ADDR_T2_RELOAD_LO: t2_reload_q[7:0] <= reg_wdata;
                UBG_ADDR_T2_RELOAD_HI: t2_reload_q[15:8] <= reg_wdata;
                UBG_ADDR_IRQ_ENABLE: irq_en_q <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // sticky done flags, a hardware set beats a same-cycle clear
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == UBG_TX_DONE_BIT && tx_done_evt) || (i == UBG_RX_DONE_BIT && rx_accept)) begin
                    irq_status_q[i] <= 1'b1; // [RQ17]
                end else if (reg_wr && reg_addr == UBG_ADDR_IRQ_CLEAR && reg_wdata[i]) begin
                    irq_status_q[i] <= 1'b0;
                end
            end
        end
    end

    // receive latch and received ninth bit, apart from the transmit shifter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_latch_q <= UBG_BYTE_RESET;
            rx9_q <= 1'b0;
        end else if (rx_accept) begin
            rx_latch_q <= rx_data; // [RQ2]
            if (mode_q == UBG_MODE_ASYNC11) begin
                rx9_q <= rx_ninth; // [RQ15]
            end
        end else if (reg_wr && reg_addr == UBG_ADDR_SERIAL_CTRL) begin
            rx9_q <= reg_wdata[UBG_RX9_BIT];
        end
    end

    // read data, valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= UBG_BYTE_RESET;
        end else if (reg_rd) begin
            case (reg_addr)
                UBG_ADDR_SERIAL_CTRL:
                    rdata_q <= {mode_q, aux_q, rx_en_q, tx9_q, rx9_q, irq_status_q};
                UBG_ADDR_DATA_BUF: rdata_q <= rx_latch_q; // [RQ2]
                UBG_ADDR_T2_CTRL: rdata_q <= {2'b00, rx_sel_q, tx_sel_q, 4'h0};
                UBG_ADDR_T1_RELOAD_LO: rdata_q <= t1_reload_q[7:0];
                UBG_ADDR_T1_RELOAD_HI: rdata_q <= t1_reload_q[15:8];
                UBG_ADDR_T1_CTRL: rdata_q <= {7'h00, t1_run_q};
                UBG_ADDR_T2_RELOAD_LO: rdata_q <= t2_reload_q[7:0];
                UBG_ADDR_T2_RELOAD_HI: rdata_q <= t2_reload_q[15:8];
                UBG_ADDR_IRQ_STATUS: rdata_q <= {6'h00, irq_status_q};
                UBG_ADDR_IRQ_ENABLE: rdata_q <= {6'h00, irq_en_q};
                default: rdata_q <= UBG_BYTE_RESET;
            endcase
        end else begin
            rdata_q <= UBG_BYTE_RESET;
        end
    end

    // transmit engine, also runs the half-duplex synchronous transfers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_q <= UBG_TX_IDLE;
            tx_sh_q <= 11'h7FF;
            tx_bits_q <= 4'h0;
            tx_cnt_q <= '0;
            sync_rx_q <= 1'b0;
            shift_clk_q <= 1'b1;
            tx_done_evt <= 1'b0;
        end else begin
            tx_done_evt <= 1'b0;
            if (wr_buf && is_async) begin
                // start, data LSB first, ninth bit or stop, stop
                tx_sh_q <= {1'b1, (mode_q == UBG_MODE_ASYNC11) ? tx9_q : 1'b1, reg_wdata, 1'b0}; // [RQ1] [RQ15]
                tx_bits_q <= (mode_q == UBG_MODE_ASYNC11) ? UBG_ASYNC11_BITS : UBG_ASYNC10_BITS; // [RQ14]
                tx_cnt_q <= per - 1'b1;
                tx_state_q <= UBG_TX_ASYNC;
            end else if (wr_buf && mode_q == UBG_MODE_SYNC) begin
                tx_sh_q <= {3'b111, reg_wdata}; // [RQ1] [RQ13]
                tx_bits_q <= UBG_SYNC_BITS;
                tx_cnt_q <= '0;
                sync_rx_q <= 1'b0;
                tx_state_q <= UBG_TX_SYNC;
            end else begin
                case (tx_state_q)
                    UBG_TX_IDLE: begin
                        shift_clk_q <= 1'b1;
                        // synchronous receive begins once enabled and the last byte was taken
                        if (mode_q == UBG_MODE_SYNC && rx_en_q && !irq_status_q[UBG_RX_DONE_BIT]) begin
                            tx_bits_q <= UBG_SYNC_BITS; // [RQ18]
                            tx_cnt_q <= '0;
                            sync_rx_q <= 1'b1;
                            tx_state_q <= UBG_TX_SYNC;
                        end
                    end
                    UBG_TX_ASYNC: begin
                        if (tx_cnt_q == '0) begin
                            tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                            tx_cnt_q <= per - 1'b1;
                            tx_bits_q <= tx_bits_q - 1'b1;
                            if (tx_bits_q == 4'h1) begin
                                tx_done_evt <= 1'b1; // [RQ17]
                                tx_state_q <= UBG_TX_IDLE;
                            end
                        end else begin
                            tx_cnt_q <= tx_cnt_q - 1'b1;
                        end
                    end
                    UBG_TX_SYNC: begin
                        // shift clock low in the first half, peer samples on its rise
                        tx_cnt_q <= (tx_cnt_q == per - 1'b1) ? '0 : tx_cnt_q + 1'b1;
                        if (tx_cnt_q == '0) begin
                            shift_clk_q <= 1'b0; // [RQ13]
                        end
                        if (tx_cnt_q == half) begin
                            shift_clk_q <= 1'b1;
                            if (sync_rx_q) begin
                                tx_sh_q[7:0] <= {rxd_s_q, tx_sh_q[7:1]};
                            end
                        end
                        if (tx_cnt_q == per - 1'b1) begin
                            if (!sync_rx_q) begin
                                tx_sh_q <= {1'b1, tx_sh_q[10:1]};
                            end
                            tx_bits_q <= tx_bits_q - 1'b1;
                            if (tx_bits_q == 4'h1) begin
                                tx_done_evt <= !sync_rx_q;
                                tx_state_q <= UBG_TX_IDLE;
                            end
                        end
                        if (sync_rx_q && !rx_en_q) begin
                            tx_state_q <= UBG_TX_IDLE; // [RQ18]
                        end
                    end
                    default: tx_state_q <= UBG_TX_IDLE;
                endcase
            end
        end
    end

    // asynchronous receive engine with mid-bit sampling
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_q <= UBG_RX_IDLE;
            rx_sh_q <= 9'h000;
            rx_bits_q <= 4'h0;
            rx_cnt_q <= '0;
            rx_done_evt <= 1'b0;
        end else begin
            rx_done_evt <= 1'b0;
            case (rx_state_q)
                UBG_RX_IDLE: begin
                    if (rx_en_q && is_async && rxd_prev_q && !rxd_s_q) begin
                        rx_cnt_q <= half; // [RQ18]
                        rx_state_q <= UBG_RX_START;
                    end
                end
                UBG_RX_START: begin
                    if (rx_cnt_q == '0) begin
                        // a start bit gone high again was a glitch
                        rx_state_q <= rxd_s_q ? UBG_RX_IDLE : UBG_RX_DATA;
                        rx_cnt_q <= per - 1'b1;
                        rx_bits_q <= (mode_q == UBG_MODE_ASYNC11) ? UBG_RX9_BITS : UBG_RX8_BITS;
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 1'b1;
                    end
                end
                UBG_RX_DATA: begin
                    if (rx_cnt_q == '0) begin
                        rx_cnt_q <= per - 1'b1;
                        if (rx_bits_q == 4'h0) begin
                            rx_done_evt <= rxd_s_q; // stop bit must be high
                            rx_state_q <= UBG_RX_IDLE;
                        end else begin
                            rx_sh_q <= {rxd_s_q, rx_sh_q[8:1]};
                            rx_bits_q <= rx_bits_q - 1'b1;
                        end
                    end else begin
                        rx_cnt_q <= rx_cnt_q - 1'b1;
                    end
                end
                default: rx_state_q <= UBG_RX_IDLE;
            endcase
            if (!rx_en_q) begin
                rx_state_q <= UBG_RX_IDLE; // [RQ18]
            end
        end
    end

    // completed receive frame from either engine
    logic sync_rx_done;
    assign sync_rx_done = (tx_state_q == UBG_TX_SYNC) && sync_rx_q && rx_en_q
                          && (tx_cnt_q == per - 1'b1) && (tx_bits_q == 4'h1);
    assign rx_data = sync_rx_done ? tx_sh_q[7:0]
                   : ((mode_q == UBG_MODE_ASYNC11) ? rx_sh_q[7:0] : rx_sh_q[8:1]);
    assign rx_ninth = rx_sh_q[8];
    assign rx_accept = sync_rx_done
                       || (rx_done_evt && rx_en_q
                           && !(mode_q == UBG_MODE_ASYNC11 && aux_q && !rx_ninth)); // [RQ16] [RQ18]

    // pins and interrupt
    assign txd_out = (tx_state_q == UBG_TX_ASYNC) ? tx_sh_q[0] : shift_clk_q;
    assign rxd_out = tx_sh_q[0];
    assign rxd_oe = (tx_state_q == UBG_TX_SYNC) && !sync_rx_q; // [RQ13]
    assign reg_rdata = rdata_q;
    assign irq = |(irq_status_q & irq_en_q);

endmodule // ubg_uart
`default_nettype wire

// *** tb/ubg_peer.sv ***
// ubg_peer: behavioural serial peer on the far side of the txd and rxd pins.
// assumes its tasks are called from a process aligned to clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module ubg_peer (
    input wire logic clk_sys,
    input wire logic txd_out,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    output logic rxd_in
);
    logic line_q = 1'b1;
    // rx pin level: the device wins while it drives, else the peer (idle mark)
    assign rxd_in = rxd_oe ? rxd_out : line_q;
    // send nb bits lsb first, per cycles each, then back to idle
    task automatic send(input logic [10:0] bits, input int nb, input int per);
        for (int i = 0; i < nb; i++) begin
            line_q <= bits[i];
            repeat (per) @(posedge clk_sys);
        end
        line_q <= 1'b1;
    endtask
    // time the start bit, then sample the ten later bits mid-period
    task automatic grab(input int per, output int width, output logic [9:0] got);
        width = 0;
        got = '0;
        for (int i = 0; i < 400 && txd_out; i++) @(posedge clk_sys);
        while (!txd_out && width < 5000) begin
            width++;
            @(posedge clk_sys);
        end
        repeat (per / 2) @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            got[i] = txd_out;
            repeat (per) @(posedge clk_sys);
        end
    endtask
    // sample the rx pin at each rising shift clock, eight bits
    task automatic grab_sync(output logic [7:0] got);
        logic prev;
        int n;
        got = '0;
        n = 0;
        prev = txd_out;
        for (int i = 0; i < 400 && n < 8; i++) begin
            @(posedge clk_sys);
            if (txd_out && !prev) begin
                got[n] = rxd_in;
                n++;
            end
            prev = txd_out;
        end
    endtask
endmodule // ubg_peer
`default_nettype wire

// *** tb/ubg_uart_monitor.sv ***
// ubg_uart_monitor: port-level assertions for the serial buffer and baud generator.
// assumes it is bound to ubg_uart and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module ubg_uart_monitor
    import ubg_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic txd_out,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    input wire logic irq
);
    logic [7:0] ctrl_q;
    logic [7:0] en_q;
    logic [1:0] mode;
    logic buf_wr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // shadow copies of serial control and interrupt enable, as software wrote them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= UBG_BYTE_RESET;
            en_q <= UBG_BYTE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == UBG_ADDR_SERIAL_CTRL) ctrl_q <= reg_wdata;
            if (reg_addr == UBG_ADDR_IRQ_ENABLE) en_q <= reg_wdata;
        end
    end
    // decoded frame mode and buffer write
    assign mode = ctrl_q[UBG_MODE_HI_BIT:UBG_MODE_LO_BIT];
    assign buf_wr = reg_wr && (reg_addr == UBG_ADDR_DATA_BUF);

    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside the answer cycle");
    a_oe_sync_only: assert property (rxd_oe |-> mode == UBG_MODE_SYNC)
        else $error("rx pin driven outside synchronous mode");
    a_irq_masked: assert property (irq |-> (en_q[UBG_TX_DONE_BIT] || en_q[UBG_RX_DONE_BIT]))
        else $error("interrupt high with both sources disabled");
    a_tx_start_low: assert property (buf_wr && mode[0] |=> !txd_out)
        else $error("no start bit after buffer write");
    a_rsvd_silent: assert property (buf_wr && mode == UBG_MODE_RSVD |=> txd_out [*8])
        else $error("reserved mode sent something");
    a_sync_slow_clk: assert property (buf_wr && mode == UBG_MODE_SYNC && !ctrl_q[UBG_AUX_BIT]
        |=> ##1 !txd_out [*6] ##1 txd_out)
        else $error("slow shift clock phase wrong");
    a_sync_fast_clk: assert property (buf_wr && mode == UBG_MODE_SYNC && ctrl_q[UBG_AUX_BIT]
        |=> ##1 !txd_out [*2] ##1 txd_out)
        else $error("fast shift clock phase wrong");
    a_sync_first_bit: assert property (buf_wr && mode == UBG_MODE_SYNC
        |=> rxd_oe && (rxd_out == $past(reg_wdata[0])))
        else $error("first synchronous bit not the lsb");

    c_async11_send: cover property (buf_wr && mode == UBG_MODE_ASYNC11);
    c_sync_drive: cover property (rxd_oe);
    c_irq_rise: cover property ($rose(irq));
endmodule // ubg_uart_monitor

bind ubg_uart ubg_uart_monitor u_mon (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .irq(irq));
`default_nettype wire

// *** tb/ubg_uart_tb_top.sv ***
// ubg_uart_tb_top: self-checking bench for the serial buffer and baud generator.
// assumes the register port of ubg_uart, the peer model and one 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module ubg_uart_tb_top
    import ubg_pkg::*;
;
    typedef struct {logic [7:0] ctrl; logic [7:0] baud; logic [7:0] sel; logic [7:0] data; int per;} ubg_row_t;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic txd_out, rxd_in, rxd_out, rxd_oe, irq;
    logic [7:0] rv;
    logic [9:0] got;
    int width;
    int fail_count = 0;
    int n_tests = 0;
    // async transmit cases: reloads are 0x0011 (first) and 0x0013 (second)
    ubg_row_t rows [4] = '{
        '{8'h40, 8'h00, 8'h00, 8'hA5, 17},
        '{8'h40, 8'h80, 8'h00, 8'h3D, 272},
        '{8'hC8, 8'h00, 8'h10, 8'h81, 19},
        '{8'hC0, 8'h00, 8'h20, 8'h7F, 19}
    };
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    ubg_uart dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txd_out(txd_out), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .irq(irq));
    ubg_peer peer (.clk_sys(clk_sys), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in));

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes, then a spare edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, rv);
        chk(rv, exp);
    endtask
    // poll a status bit under a bound; running out ends the run
    task automatic wait_flag(input int b);
        for (int i = 0; i < 3000; i++) begin
            rd(UBG_ADDR_IRQ_STATUS, rv);
            if (rv[b] === 1'b1) return;
        end
        fail_count++;
        close_out();
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        // idle levels, reset values, write-only and unmapped reads, reserved mode
        chk(txd_out, 1'b1);
        chk({irq, rxd_oe}, 2'b00);
        rdchk(UBG_ADDR_DATA_BUF, UBG_BYTE_RESET);
        rdchk(UBG_ADDR_SERIAL_CTRL, UBG_BYTE_RESET);
        rdchk(UBG_ADDR_BAUD_CTRL, 8'h00);
        rdchk(8'h55, 8'h00);
        wr(UBG_ADDR_SERIAL_CTRL, 8'h80);
        wr(UBG_ADDR_DATA_BUF, 8'hFF);
        repeat (10) @(posedge clk_sys);
        rdchk(UBG_ADDR_IRQ_STATUS, 8'h00);
        rdchk(UBG_ADDR_DATA_BUF, 8'h00);
        $display("test reset and reserved mode done");
        wr(UBG_ADDR_T1_CTRL, 8'h00);
        wr(UBG_ADDR_T1_RELOAD_LO, 8'h11);
        wr(UBG_ADDR_T1_RELOAD_HI, 8'h00);
        wr(UBG_ADDR_T2_RELOAD_LO, 8'h13);
        wr(UBG_ADDR_T2_RELOAD_HI, 8'h00);
        foreach (rows[k]) begin
            wr(UBG_ADDR_BAUD_CTRL, rows[k].baud);
            wr(UBG_ADDR_T2_CTRL, rows[k].sel);
            wr(UBG_ADDR_SERIAL_CTRL, rows[k].ctrl);
            fork
                peer.grab(rows[k].per, width, got);
                wr(UBG_ADDR_DATA_BUF, rows[k].data);
            join
            chk(width, rows[k].per);
            chk(got, {1'b1, rows[k].ctrl[7] ? rows[k].ctrl[3] : 1'b1, rows[k].data});
            wait_flag(UBG_TX_DONE_BIT);
            rdchk(UBG_ADDR_IRQ_STATUS, 8'h02);
            wr(UBG_ADDR_IRQ_CLEAR, 8'h02);
            rdchk(UBG_ADDR_IRQ_STATUS, 8'h00);
        end
        $display("test async transmit rows done");
        // reception, interrupt enable, mask and clear
        wr(UBG_ADDR_BAUD_CTRL, 8'h00);
        wr(UBG_ADDR_T2_CTRL, 8'h00);
        wr(UBG_ADDR_SERIAL_CTRL, 8'h50);
        peer.send({1'b1, 8'h5A, 1'b0}, 10, 17);
        wait_flag(UBG_RX_DONE_BIT);
        rdchk(UBG_ADDR_DATA_BUF, 8'h5A);
        wr(UBG_ADDR_IRQ_ENABLE, 8'h01);
        chk(irq, 1'b1);
        wr(UBG_ADDR_IRQ_ENABLE, 8'h00);
        chk(irq, 1'b0);
        wr(UBG_ADDR_IRQ_ENABLE, 8'h01);
        wr(UBG_ADDR_IRQ_CLEAR, 8'h01);
        chk(irq, 1'b0);
        // receive disabled: frame ignored
        wr(UBG_ADDR_SERIAL_CTRL, 8'h40);
        peer.send({1'b1, 8'hC3, 1'b0}, 10, 17);
        repeat (20) @(posedge clk_sys);
        rdchk(UBG_ADDR_DATA_BUF, 8'h5A);
        rdchk(UBG_ADDR_IRQ_STATUS, 8'h00);
        // eleven-bit frames with address filtering on the ninth bit
        wr(UBG_ADDR_SERIAL_CTRL, 8'hF0);
        peer.send({2'b10, 8'h33, 1'b0}, 11, 17);
        repeat (20) @(posedge clk_sys);
        rdchk(UBG_ADDR_DATA_BUF, 8'h5A);
        rdchk(UBG_ADDR_IRQ_STATUS, 8'h00);
        peer.send({2'b11, 8'h96, 1'b0}, 11, 17);
        wait_flag(UBG_RX_DONE_BIT);
        rdchk(UBG_ADDR_DATA_BUF, 8'h96);
        rd(UBG_ADDR_SERIAL_CTRL, rv);
        chk(rv[UBG_RX9_BIT], 1'b1);
        chk(irq, 1'b1);
        wr(UBG_ADDR_IRQ_CLEAR, 8'h01);
        $display("test receive paths done");
        // synchronous transmit at both rates, with divide-by-16 set to no effect
        wr(UBG_ADDR_BAUD_CTRL, 8'h80);
        for (int a = 0; a < 2; a++) begin
            wr(UBG_ADDR_SERIAL_CTRL, a[0] ? 8'h20 : 8'h00);
            fork
                peer.grab_sync(rv);
                wr(UBG_ADDR_DATA_BUF, 8'h96 ^ a[7:0]);
            join
            chk(rv, 8'h96 ^ a[7:0]);
            wait_flag(UBG_TX_DONE_BIT);
            wr(UBG_ADDR_IRQ_CLEAR, 8'h02);
        end
        wr(UBG_ADDR_SERIAL_CTRL, 8'h10);
        wait_flag(UBG_RX_DONE_BIT);
        rdchk(UBG_ADDR_DATA_BUF, 8'hFF);
        $display("test synchronous transmit done");
        close_out();
    end
endmodule // ubg_uart_tb_top
`default_nettype wire
